// File: verilog/hm_pkg.sv
`default_nettype none
package hm_pkg;
    // device register byte offsets, 16-bit words at even addresses
    localparam logic [7:0] A_UMUL_16 = 8'h00; // unsigned_multiply_entry
    localparam logic [7:0] A_SMUL_16 = 8'h02; // signed_multiply_entry
    localparam logic [7:0] A_UMAC_16 = 8'h04; // unsigned_accumulate_entry
    localparam logic [7:0] A_SMAC_16 = 8'h06; // signed_accumulate_entry
    localparam logic [7:0] A_OP2_16 = 8'h08; // second_operand_16
    localparam logic [7:0] A_LEG_LO = 8'h0A; // legacy_result_low
    localparam logic [7:0] A_LEG_HI = 8'h0C; // legacy_result_high
    localparam logic [7:0] A_SUM_EXTENSION = 8'h0E; // sum_extension
    localparam logic [7:0] A_UMUL_LO = 8'h10;
    localparam logic [7:0] A_UMUL_HI = 8'h12;
    localparam logic [7:0] A_SMUL_LO = 8'h14;
    localparam logic [7:0] A_SMUL_HI = 8'h16;
    localparam logic [7:0] A_UMAC_LO = 8'h18;
    localparam logic [7:0] A_UMAC_HI = 8'h1A;
    localparam logic [7:0] A_SMAC_LO = 8'h1C;
    localparam logic [7:0] A_SMAC_HI = 8'h1E;
    localparam logic [7:0] A_OP2_LO = 8'h20; // second_operand_low
    localparam logic [7:0] A_OP2_HI = 8'h22; // second_operand_high
    localparam logic [7:0] A_RESULT_WORD_0 = 8'h24; // result_word_0, words 1..3 follow
    localparam logic [7:0] A_CTL0 = 8'h2C; // multiplier_control_0
    // multiplier_control_0 bit positions
    localparam int CTL_DLY_EN = 0; // delayed_write_enable
    localparam int CTL_DLY32 = 1; // delay_until_32bit_select
    localparam int CTL_CARRY = 2; // product_carry_flag, read only
    localparam int CTL_OP1W = 3; // first operand is 32 bits, read only
    localparam int CTL_OP2W = 4; // second operand is 32 bits, read only
    // latencies {carry, word3, word2, word1, word0} in clock cycles
    localparam logic [19:0] LAT_N_N = 20'h34433;
    localparam logic [19:0] LAT_W_N = 20'h77653;
    localparam logic [19:0] LAT_N_W = 20'h44433;
    localparam logic [19:0] LAT_W_W = 20'h66533;
    localparam logic [15:0] REG_RST = 16'h0000;
    // operation modes: bit0 signed, bit1 accumulate
    typedef enum logic [1:0] {
        HM_UMUL = 2'b00,
        HM_SMUL = 2'b01,
        HM_UMAC = 2'b10,
        HM_SMAC = 2'b11
    } hm_mode_e;
    // avalon word indices of the controller
    localparam logic [1:0] AV_DATA = 2'h0;
    localparam logic [1:0] AV_CMD = 2'h1;
    localparam logic [1:0] AV_STAT = 2'h2;
    localparam logic [1:0] AV_RDATA = 2'h3;
    localparam int CMD_READ = 8; // command bit: 1 read, 0 write
    localparam int CMD_BYTE = 9; // command bit: byte access
    typedef enum logic [1:0] {
        CPU_IDLE = 2'b00,
        CPU_ISSUE = 2'b01,
        CPU_CAPT = 2'b10
    } hm_cpu_e;
endpackage
`default_nettype wire

// File: verilog/hm_bus_if.sv
`timescale 1ns/1ps
`default_nettype none
interface hm_bus_if;
    logic wr; // write request, held until taken
    logic rd; // read request
    logic bsel; // byte access
    logic [7:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata; // valid the cycle after a read is taken
    logic stall; // delayed write in force
    modport dev (input wr, rd, bsel, addr, wdata, output rdata, stall);
    modport cpu (output wr, rd, bsel, addr, wdata, input rdata, stall);
endinterface
`default_nettype wire

// File: verilog/hm_dev.sv
// How it works
// - low-word first-operand write selects mode only
// - first operand wide only after high-word write
// - first operand and mode kept between operations
// - twelve first-operand addresses, four modes
// - 16-bit second operand write starts operation
// - low second word held, high word starts
// - lone second-operand high write is ignored
// - byte writes sign-extended in signed modes
// - 24-bit high byte follows low-word signedness
// - stored high word kept, ignored when narrow
// - operand change mid-operation invalidates pending words
// - delayed write stalls until 64/32 result
// - 64-bit result, signed modes sign-extended
// - software preloads signed accumulate sign-extended
// - software leaves result words alone while busy
// - legacy low/high alias result words 0, 1
// - sign/carry from 32 or 64 bits
// - unsigned multiply: extension 0, carry 0
// - signed modes: extension is sign
// - unsigned accumulate: extension and carry mirror
// - accumulate carry reported, never fed back
// - software detects signed accumulate overflow itself
// - narrow result words 0, 1 readable three cycles later, words 2, 3 after four
//
// Decided for this implementation: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module hm_dev (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    hm_bus_if.dev bus,
    output logic busy_o,
    output logic carry_o
);
    // operand and mode state
    logic [15:0] op1_lo_ff, op1_hi_ff, op2_lo_ff, op2_hi_ff;
    logic op1_wide_ff, op2_wide_ff, expect_hi_ff;
    hm_pkg::hm_mode_e mode_ff;
    // computation tracking
    logic [63:0] base_ff, pend_ff;
    logic [15:0] psx_ff, sum_extension_ff, rdata_ff;
    logic pcy_ff, carry_ff, busy_ff, stall_ff, dly_en_ff, dly32_ff;
    logic [19:0] lat_ff;
    logic [3:0] cnt_ff;
    logic [15:0] res_ff [0:3];
    // decoded write events
    logic wr_ok, op1_lo_wr, op1_hi_wr, op2_go, second_operand_low_wr, second_operand_high_go, start;
    logic sgn;
    hm_pkg::hm_mode_e wmode;
    logic [15:0] wval;
    logic [63:0] a64, b64, prod, base, res_new, cur_res;
    logic [64:0] s65;
    logic [32:0] s33;
    logic [31:0] r32;
    logic narrow, op2w, sign, cy, nxt_stall;
    logic [15:0] sx, b_hi;
    logic [19:0] lat_new;

    // writes are held off while the delayed-write stall stands
    assign wr_ok = bus.wr && !stall_ff;
    assign cur_res = {res_ff[3], res_ff[2], res_ff[1], res_ff[0]};

    // address decode of first-operand entries and their modes
    always_comb begin
        op1_lo_wr = 1'b0;
        op1_hi_wr = 1'b0;
        wmode = mode_ff;
        case (bus.addr)
            hm_pkg::A_UMUL_16, hm_pkg::A_UMUL_LO: begin
                op1_lo_wr = 1'b1;
                wmode = hm_pkg::HM_UMUL;
            end
            hm_pkg::A_SMUL_16, hm_pkg::A_SMUL_LO: begin
                op1_lo_wr = 1'b1;
                wmode = hm_pkg::HM_SMUL;
            end
            hm_pkg::A_UMAC_16, hm_pkg::A_UMAC_LO: begin
                op1_lo_wr = 1'b1;
                wmode = hm_pkg::HM_UMAC;
            end
            hm_pkg::A_SMAC_16, hm_pkg::A_SMAC_LO: begin
                op1_lo_wr = 1'b1;
                wmode = hm_pkg::HM_SMAC;
            end
            hm_pkg::A_UMUL_HI, hm_pkg::A_SMUL_HI,
            hm_pkg::A_UMAC_HI, hm_pkg::A_SMAC_HI: op1_hi_wr = 1'b1;
            default: op1_lo_wr = 1'b0;
        endcase
        op1_lo_wr = op1_lo_wr && wr_ok;
        op1_hi_wr = op1_hi_wr && wr_ok;
    end

    assign op2_go = wr_ok && bus.addr == hm_pkg::A_OP2_16;
    assign second_operand_low_wr = wr_ok && bus.addr == hm_pkg::A_OP2_LO;
    // high second word counts only after a low one
    assign second_operand_high_go = wr_ok && bus.addr == hm_pkg::A_OP2_HI
        && expect_hi_ff;
    assign start = op2_go || second_operand_high_go;

    // byte data extension; high word of a 24-bit value uses stored mode
    assign sgn = op1_lo_wr ? wmode[0] : mode_ff[0];
    assign wval = bus.bsel ? {{8{sgn && bus.wdata[7]}}, bus.wdata[7:0]}
        : bus.wdata;

    // product and accumulation of the operation being started
    always_comb begin
        op2w = second_operand_high_go;
        b_hi = wval;
        narrow = !op1_wide_ff && !op2w;
        a64 = op1_wide_ff
            ? {{32{mode_ff[0] && op1_hi_ff[15]}}, op1_hi_ff, op1_lo_ff}
            : {{48{mode_ff[0] && op1_lo_ff[15]}}, op1_lo_ff};
        b64 = op2w ? {{32{mode_ff[0] && b_hi[15]}}, b_hi, op2_lo_ff}
            : {{48{mode_ff[0] && wval[15]}}, wval};
        prod = a64 * b64;
        // accumulation base is the result words now, or as held at the low second-word write
        base = second_operand_high_go ? base_ff : cur_res;
        s65 = {1'b0, base} + {1'b0, prod};
        s33 = {1'b0, base[31:0]} + {1'b0, prod[31:0]};
        r32 = mode_ff[1] ? s33[31:0] : prod[31:0];
        if (narrow) begin
            res_new = {{32{mode_ff[0] && r32[31]}}, r32};
        end else begin
            res_new = mode_ff[1] ? s65[63:0] : prod;
        end
        sign = narrow ? res_new[31] : res_new[63];
        // carry out is reported only, never added into later sums
        cy = mode_ff[1] ? (narrow ? s33[32] : s65[64]) : 1'b0;
        case (mode_ff)
            hm_pkg::HM_UMUL: sx = 16'h0000;
            hm_pkg::HM_UMAC: sx = {15'h0000, cy};
            default: sx = {16{sign}};
        endcase
        if (mode_ff == hm_pkg::HM_SMUL) begin
            cy = sign;
        end
        if (narrow) begin
            lat_new = hm_pkg::LAT_N_N;
        end else if (!op2w) begin
            lat_new = hm_pkg::LAT_W_N;
        end else begin
            lat_new = op1_wide_ff ? hm_pkg::LAT_W_W : hm_pkg::LAT_N_W;
        end
    end

    // first operand: low write sets mode and narrows, high widens
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            op1_lo_ff <= hm_pkg::REG_RST;
            op1_hi_ff <= hm_pkg::REG_RST;
            op1_wide_ff <= 1'b0;
            mode_ff <= hm_pkg::HM_UMUL;
        end else if (op1_lo_wr) begin
            op1_lo_ff <= wval;
            mode_ff <= wmode;
            op1_wide_ff <= 1'b0;
        end else if (op1_hi_wr) begin
            op1_hi_ff <= wval;
            op1_wide_ff <= 1'b1;
        end
    end

    // second operand words and the wait for a high word
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            op2_lo_ff <= hm_pkg::REG_RST;
            op2_hi_ff <= hm_pkg::REG_RST;
            op2_wide_ff <= 1'b0;
            expect_hi_ff <= 1'b0;
            base_ff <= 64'h0000000000000000;
        end else if (op2_go) begin
            op2_lo_ff <= wval;
            op2_wide_ff <= 1'b0;
            expect_hi_ff <= 1'b0;
        end else if (second_operand_low_wr) begin
            op2_lo_ff <= wval;
            expect_hi_ff <= 1'b1;
            base_ff <= cur_res;
        end else if (second_operand_high_go) begin
            op2_hi_ff <= wval;
            op2_wide_ff <= 1'b1;
            expect_hi_ff <= 1'b0;
        end
    end

    // latency counter; operand changes cancel words not yet written
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            busy_ff <= 1'b0;
            cnt_ff <= 4'h0;
            lat_ff <= 20'h00000;
            pend_ff <= 64'h0000000000000000;
            pcy_ff <= 1'b0;
            psx_ff <= hm_pkg::REG_RST;
        end else if (start) begin
            busy_ff <= 1'b1;
            cnt_ff <= 4'h1;
            lat_ff <= lat_new;
            pend_ff <= res_new;
            pcy_ff <= cy;
            psx_ff <= sx;
        end else if (op1_lo_wr || op1_hi_wr || second_operand_low_wr) begin
            busy_ff <= 1'b0;
        end else if (busy_ff) begin
            cnt_ff <= cnt_ff + 4'h1;
            if (cnt_ff == lat_ff[15:12]) begin
                busy_ff <= 1'b0;
            end
        end
    end

    // result words fill in as their latency elapses
    genvar k;
    generate
        for (k = 0; k < 4; k++) begin : g_res
            logic sw_hit;
            assign sw_hit = wr_ok && (bus.addr == 8'(hm_pkg::A_RESULT_WORD_0 + 2 * k)
                || (k < 2 && bus.addr == 8'(hm_pkg::A_LEG_LO + 2 * k)));
            always_ff @(posedge clk_sys_i or posedge rst_i) begin
                if (rst_i) begin
                    res_ff[k] <= hm_pkg::REG_RST;
                end else if (sw_hit) begin
                    res_ff[k] <= wval;
                end else if (busy_ff && !start
                        && cnt_ff == lat_ff[4*k +: 4]) begin
                    res_ff[k] <= pend_ff[16*k +: 16];
                end
            end
        end
    endgenerate

    // sum extension and carry arrive with their own latency
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            sum_extension_ff <= hm_pkg::REG_RST;
            carry_ff <= 1'b0;
        end else if (busy_ff && !start && cnt_ff == lat_ff[19:16]) begin
            sum_extension_ff <= psx_ff;
            carry_ff <= pcy_ff;
        end
    end

    // control bits and the registered stall
    assign nxt_stall = dly_en_ff && (start || (busy_ff
        && cnt_ff < (dly32_ff ? lat_ff[7:4] : lat_ff[15:12])));
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            dly_en_ff <= 1'b0;
            dly32_ff <= 1'b0;
            stall_ff <= 1'b0;
        end else begin
            stall_ff <= nxt_stall;
            if (wr_ok && bus.addr == hm_pkg::A_CTL0) begin
                dly_en_ff <= wval[hm_pkg::CTL_DLY_EN];
                dly32_ff <= wval[hm_pkg::CTL_DLY32];
            end
        end
    end

    // read data, one cycle after the read is taken
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_ff <= hm_pkg::REG_RST;
        end else if (bus.rd) begin
            case (bus.addr)
                hm_pkg::A_RESULT_WORD_0, hm_pkg::A_LEG_LO: rdata_ff <= res_ff[0];
                8'h26, hm_pkg::A_LEG_HI: rdata_ff <= res_ff[1];
                8'h28: rdata_ff <= res_ff[2];
                8'h2A: rdata_ff <= res_ff[3];
                hm_pkg::A_SUM_EXTENSION: rdata_ff <= sum_extension_ff;
                hm_pkg::A_CTL0: rdata_ff <= {11'h000, op2_wide_ff,
                    op1_wide_ff, carry_ff, dly32_ff, dly_en_ff};
                default: rdata_ff <= 16'h0000; // unmapped reads zero
            endcase
        end
    end

    assign bus.rdata = rdata_ff;
    assign bus.stall = stall_ff;
    assign busy_o = busy_ff;
    assign carry_o = carry_ff;
endmodule
`default_nettype wire

// File: verilog/hm_cpu.sv
`timescale 1ns/1ps
`default_nettype none
module hm_cpu (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic [1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    hm_bus_if.cpu bus
);
    logic wait_ff; // waitrequest, low for one cycle per access
    logic [31:0] rd_ff;
    logic [15:0] data_ff, rdata_ff;
    logic [7:0] addr_ff;
    logic bsel_ff, wr_ff, rd_req_ff, is_read_ff;
    hm_pkg::hm_cpu_e state_ff;
    logic accept;

    assign accept = (avs_read_i || avs_write_i) && !wait_ff;

    // every access answers two edges after it is raised
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            wait_ff <= 1'b1;
            rd_ff <= 32'h00000000;
        end else begin
            wait_ff <= !(wait_ff && (avs_read_i || avs_write_i));
            if (wait_ff && avs_read_i) begin
                case (avs_address_i)
                    hm_pkg::AV_DATA: rd_ff <= {16'h0000, data_ff};
                    hm_pkg::AV_STAT: rd_ff <= {31'h00000000,
                        state_ff != hm_pkg::CPU_IDLE};
                    hm_pkg::AV_RDATA: rd_ff <= {16'h0000, rdata_ff};
                    default: rd_ff <= 32'h00000000;
                endcase
            end
        end
    end

    // write data holding register
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            data_ff <= 16'h0000;
        end else if (accept && avs_write_i
                && avs_address_i == hm_pkg::AV_DATA) begin
            data_ff <= avs_writedata_i[15:0];
        end
    end

    // access sequencer; a command while busy is dropped
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            state_ff <= hm_pkg::CPU_IDLE;
            addr_ff <= 8'h00;
            bsel_ff <= 1'b0;
            wr_ff <= 1'b0;
            rd_req_ff <= 1'b0;
            is_read_ff <= 1'b0;
            rdata_ff <= 16'h0000;
        end else begin
            case (state_ff)
                hm_pkg::CPU_IDLE: begin
                    if (accept && avs_write_i
                            && avs_address_i == hm_pkg::AV_CMD) begin
                        addr_ff <= avs_writedata_i[7:0];
                        bsel_ff <= avs_writedata_i[hm_pkg::CMD_BYTE];
                        is_read_ff <= avs_writedata_i[hm_pkg::CMD_READ];
                        rd_req_ff <= avs_writedata_i[hm_pkg::CMD_READ];
                        wr_ff <= !avs_writedata_i[hm_pkg::CMD_READ];
                        state_ff <= hm_pkg::CPU_ISSUE;
                    end
                end
                hm_pkg::CPU_ISSUE: begin
                    // reads are never held; writes wait out the stall
                    if (is_read_ff || !bus.stall) begin
                        wr_ff <= 1'b0;
                        rd_req_ff <= 1'b0;
                        state_ff <= is_read_ff ? hm_pkg::CPU_CAPT
                            : hm_pkg::CPU_IDLE;
                    end
                end
                hm_pkg::CPU_CAPT: begin
                    rdata_ff <= bus.rdata;
                    state_ff <= hm_pkg::CPU_IDLE;
                end
                default: state_ff <= hm_pkg::CPU_IDLE;
            endcase
        end
    end

    assign avs_waitrequest_o = wait_ff;
    assign avs_readdata_o = rd_ff;
    assign bus.wr = wr_ff;
    assign bus.rd = rd_req_ff;
    assign bus.bsel = bsel_ff;
    assign bus.addr = addr_ff;
    assign bus.wdata = data_ff;
endmodule
`default_nettype wire

// File: dv/hm_sva.sv
`timescale 1ns/1ps
`default_nettype none
module hm_sva (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] addr,
    input wire logic [15:0] wdata,
    input wire logic [15:0] rdata,
    input wire logic stall,
    input wire logic busy_o,
    input wire logic carry_o
);
    // one clock domain, so one clock and one reset for all
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);

    // a taken 16-bit second operand write starts work at once
    property p_start_busy;
        wr && !stall && addr == hm_pkg::A_OP2_16 |=> busy_o;
    endproperty
    a_start_busy: assert property (p_start_busy)
        else $error("no busy after second operand write");

    // busy never rises without a write taken just before
    property p_busy_cause;
        $rose(busy_o) |-> $past(wr) && !$past(stall);
    endproperty
    a_busy_cause: assert property (p_busy_cause)
        else $error("busy rose without a taken write");

    // the slowest product settles well inside this bound
    property p_busy_bound;
        $rose(busy_o) |-> ##[1:30] !busy_o;
    endproperty
    a_busy_bound: assert property (p_busy_bound)
        else $error("busy stuck high");

    // stall is launched only by a taken write: a start, or enabling delayed writes while busy
    property p_stall_cause;
        $rose(stall) |-> $past(wr);
    endproperty
    a_stall_cause: assert property (p_stall_cause)
        else $error("stall rose without a write");

    // stall lasts no longer than the widest result latency
    property p_stall_bound;
        $rose(stall) |-> ##[1:10] !stall;
    endproperty
    a_stall_bound: assert property (p_stall_bound)
        else $error("stall held too long");

    // a stalled write waits with its address and data frozen
    property p_wr_hold;
        wr && stall |=> wr && $stable(addr) && $stable(wdata);
    endproperty
    a_wr_hold: assert property (p_wr_hold)
        else $error("stalled write changed or dropped");

    // read strobe is a single-cycle pulse
    property p_rd_pulse;
        rd |=> !rd;
    endproperty
    a_rd_pulse: assert property (p_rd_pulse)
        else $error("read strobe longer than one cycle");

    // read data only moves on the edge after a read
    property p_rdata_cause;
        $changed(rdata) |-> $past(rd);
    endproperty
    a_rdata_cause: assert property (p_rdata_cause)
        else $error("read data changed without a read");

    // carry is updated only as results are filled in
    property p_carry_cause;
        $changed(carry_o) |-> busy_o || $past(busy_o);
    endproperty
    a_carry_cause: assert property (p_carry_cause)
        else $error("carry changed while idle");
endmodule
`default_nettype wire

// File: dv/hm_bench.sv
`timescale 1ns/1ps
`default_nettype none
module hm_bench;
    logic clk_sys_i; // system clock, 8 ns
    logic rst_i; // async reset, active high
    logic [1:0] av_addr; // avalon word index
    logic av_rd;
    logic av_wr;
    logic [31:0] av_wdata;
    logic [31:0] av_rdata;
    logic av_wait;
    logic busy_o;
    logic carry_o;
    int error_cnt; // mismatches seen
    int total_checks; // comparisons made
    logic [31:0] q; // avalon read data of bare calls
    hm_bus_if i_hm_bus_if ();

    hm_cpu i_hm_cpu (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .avs_address_i(av_addr), .avs_read_i(av_rd),
        .avs_write_i(av_wr), .avs_writedata_i(av_wdata),
        .avs_readdata_o(av_rdata), .avs_waitrequest_o(av_wait),
        .bus(i_hm_bus_if.cpu));
    hm_dev i_hm_dev (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .bus(i_hm_bus_if.dev), .busy_o(busy_o), .carry_o(carry_o));
    hm_sva i_hm_sva (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .wr(i_hm_bus_if.wr), .rd(i_hm_bus_if.rd),
        .addr(i_hm_bus_if.addr), .wdata(i_hm_bus_if.wdata),
        .rdata(i_hm_bus_if.rdata), .stall(i_hm_bus_if.stall),
        .busy_o(busy_o), .carry_o(carry_o));

    // free-running clock
    initial begin
        clk_sys_i = 1'b0;
        forever #4 clk_sys_i = ~clk_sys_i;
    end

    // verdict and end of run, also used when a wait runs out
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected at %0t: got %h exp %h", $time, g, e);
        end
    endtask

    task automatic timed_out();
        error_cnt++;
        $display("unexpected at %0t: wait ran out", $time);
        report_and_stop();
    endtask

    // one avalon access; request held until waitrequest is low
    task automatic av_xfer(input logic [1:0] a, input logic w,
        input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge clk_sys_i);
        av_addr <= a;
        av_wr <= w;
        av_rd <= ~w;
        av_wdata <= d;
        n = 0;
        // waitrequest is looked at on rising edges only
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (av_wait !== 1'b0 && n < 64);
        if (av_wait !== 1'b0) begin
            timed_out();
        end
        // taken at this edge: data captured, request released
        q = av_rdata;
        av_wr <= 1'b0;
        av_rd <= 1'b0;
    endtask

    // poll until the controller has finished its device access
    task automatic dev_idle();
        logic [31:0] s;
        int n;
        n = 0;
        do begin
            av_xfer(hm_pkg::AV_STAT, 1'b0, 32'h0, s);
            n++;
        end while (s[0] !== 1'b0 && n < 32);
        if (s[0] !== 1'b0) begin
            timed_out();
        end
    endtask

    task automatic dev_wr(input logic [7:0] a, input logic [15:0] d,
        input logic b = 1'b0);
        logic [31:0] q;
        av_xfer(hm_pkg::AV_DATA, 1'b1, {16'h0, d}, q);
        av_xfer(hm_pkg::AV_CMD, 1'b1, {22'h0, b, 1'b0, a}, q);
        dev_idle();
    endtask

    task automatic chk_rd(input logic [7:0] a, input logic [15:0] e);
        logic [31:0] q;
        av_xfer(hm_pkg::AV_CMD, 1'b1, {23'h0, 1'b1, a}, q);
        dev_idle();
        av_xfer(hm_pkg::AV_RDATA, 1'b0, 32'h0, q);
        chk(q[15:0], e);
    endtask

    // first n result words against a 64-bit value
    task automatic chk_res(input logic [63:0] e, input int n);
        for (int k = 0; k < n; k++) begin
            chk_rd(hm_pkg::A_RESULT_WORD_0 + 8'(2 * k), e[16 * k +: 16]);
        end
    endtask

    task automatic chk_ext(input logic [15:0] se, input logic c);
        chk_rd(hm_pkg::A_SUM_EXTENSION, se);
        chk({15'h0, carry_o}, {15'h0, c});
    endtask

    // main sequence
    initial begin
        rst_i = 1'b1;
        av_addr = 2'h0;
        av_rd = 1'b0;
        av_wr = 1'b0;
        av_wdata = 32'h0;
        error_cnt = 0;
        total_checks = 0;
        repeat (4) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        chk_rd(hm_pkg::A_SUM_EXTENSION, 16'h0000);
        chk_rd(hm_pkg::A_CTL0, 16'h0000);
        dev_wr(8'h30, 16'hABCD);
        chk_rd(8'h30, 16'h0000);
        $display("test reset done");
        // every 16-bit entry: FFFF times 2, base cleared first
        for (int m = 0; m < 4; m++) begin
            for (int k = 0; k < 4; k++) begin
                dev_wr(hm_pkg::A_RESULT_WORD_0 + 8'(2 * k), 16'h0000);
            end
            dev_wr(hm_pkg::A_UMUL_16 + 8'(2 * m), 16'hFFFF);
            dev_wr(hm_pkg::A_OP2_16, 16'h0002);
            chk_res(m[0] ? 64'hFFFF_FFFF_FFFF_FFFE :
                64'h0000_0000_0001_FFFE, m[1] ? 2 : 4);
            chk_rd(hm_pkg::A_LEG_LO, 16'hFFFE);
            chk_rd(hm_pkg::A_LEG_HI, m[0] ? 16'hFFFF : 16'h0001);
            chk_ext(m[0] ? 16'hFFFF : 16'h0000, m == 1);
        end
        // lone high second word leaves results alone
        dev_wr(hm_pkg::A_OP2_HI, 16'h0005);
        chk({15'h0, busy_o}, 16'h0000);
        chk_res(64'hFFFF_FFFF_FFFF_FFFE, 2);
        $display("test modes done");
        // wide signed first operand, then reuse it
        dev_wr(hm_pkg::A_SMUL_LO, 16'h0000);
        dev_wr(hm_pkg::A_SMUL_HI, 16'h8000);
        dev_wr(hm_pkg::A_OP2_16, 16'h0002);
        chk_res(64'hFFFF_FFFF_0000_0000, 4);
        chk_ext(16'hFFFF, 1'b1);
        dev_wr(hm_pkg::A_OP2_16, 16'h0001);
        chk_res(64'hFFFF_FFFF_8000_0000, 4);
        // high word first is ignored, width falls back to 16
        dev_wr(hm_pkg::A_SMUL_HI, 16'h7FFF);
        dev_wr(hm_pkg::A_SMUL_LO, 16'h0003);
        dev_wr(hm_pkg::A_OP2_16, 16'h0002);
        chk_res(64'h0000_0000_0000_0006, 4);
        // byte operands in signed mode
        dev_wr(hm_pkg::A_SMUL_16, 16'h0080, 1'b1);
        dev_wr(hm_pkg::A_OP2_16, 16'h00FF, 1'b1);
        chk_res(64'h0000_0000_0000_0080, 4);
        // 24-bit operand, high part as a byte
        dev_wr(hm_pkg::A_SMUL_LO, 16'h0000);
        dev_wr(hm_pkg::A_SMUL_HI, 16'h00FF, 1'b1);
        dev_wr(hm_pkg::A_OP2_16, 16'h0002);
        chk_res(64'hFFFF_FFFF_FFFE_0000, 4);
        $display("test widths done");
        // 32x32 unsigned
        dev_wr(hm_pkg::A_UMUL_LO, 16'h0000);
        dev_wr(hm_pkg::A_UMUL_HI, 16'h0001);
        dev_wr(hm_pkg::A_OP2_LO, 16'h0003);
        dev_wr(hm_pkg::A_OP2_HI, 16'h0002);
        chk_res(64'h0000_0002_0003_0000, 4);
        // unsigned accumulate wraps, carry is not fed back
        dev_wr(hm_pkg::A_RESULT_WORD_0, 16'hFFFF);
        dev_wr(hm_pkg::A_RESULT_WORD_0 + 8'h02, 16'hFFFF);
        dev_wr(hm_pkg::A_UMAC_16, 16'h0001);
        dev_wr(hm_pkg::A_OP2_16, 16'h0001);
        chk_res(64'h0, 2);
        chk_ext(16'h0001, 1'b1);
        dev_wr(hm_pkg::A_OP2_16, 16'h0001);
        chk_res(64'h1, 2);
        chk_ext(16'h0000, 1'b0);
        // signed accumulate overflow: carry differs from extension sign
        dev_wr(hm_pkg::A_RESULT_WORD_0, 16'hFFFF);
        dev_wr(hm_pkg::A_RESULT_WORD_0 + 8'h02, 16'h7FFF);
        dev_wr(hm_pkg::A_RESULT_WORD_0 + 8'h04, 16'h0000);
        dev_wr(hm_pkg::A_RESULT_WORD_0 + 8'h06, 16'h0000);
        dev_wr(hm_pkg::A_SMAC_16, 16'h0001);
        dev_wr(hm_pkg::A_OP2_16, 16'h0001);
        chk_res(64'hFFFF_FFFF_8000_0000, 4);
        chk_ext(16'hFFFF, 1'b0);
        $display("test accumulate done");
        // delayed writes around a full 32x32 product
        dev_wr(hm_pkg::A_CTL0, 16'h0001);
        chk_rd(hm_pkg::A_CTL0, 16'h0001);
        dev_wr(hm_pkg::A_UMUL_LO, 16'hFFFF);
        dev_wr(hm_pkg::A_UMUL_HI, 16'hFFFF);
        dev_wr(hm_pkg::A_OP2_LO, 16'hFFFF);
        // start, then a write at once: it must wait out the stall,
        // else it aborts the product and words 2 and 3 go stale
        av_xfer(hm_pkg::AV_CMD, 1'b1, {24'h0, hm_pkg::A_OP2_HI}, q);
        av_xfer(hm_pkg::AV_CMD, 1'b1, {24'h0, hm_pkg::A_UMUL_HI}, q);
        dev_idle();
        chk_res(64'hFFFF_FFFE_0000_0001, 4);
        chk_rd(hm_pkg::A_CTL0, 16'h0019);
        chk_ext(16'h0000, 1'b0);
        dev_wr(hm_pkg::A_CTL0, 16'h0000);
        $display("test delayed write done");
        report_and_stop();
    end
endmodule
`default_nettype wire
